// ### core/pfpp_pkg.sv
// Purpose: Shared constants and types for the parallel flash programming port.
// Assumes: One 200 MHz reference clock for both ends.
// Notes: Command codes and transfer types are fixed by the port protocol.

// ============================================================
// Package
package pfpp_pkg;
    // Widths of the port.
    localparam int DATA_W = 16;
    localparam int MODE_W = 4;
    localparam int ADDR_W = 32;
    localparam int BYTE_W = 8;

    // Undriven pins read high through their pull-ups.
    localparam logic [DATA_W-1:0] BUS_PULLUP = 16'hFFFF;

    // Transfer type codes.
    localparam logic [MODE_W-1:0] MODE_CMD = 4'h0;
    localparam logic [MODE_W-1:0] MODE_ADDR_LO = 4'h1;
    localparam logic [MODE_W-1:0] MODE_ADDR_HI = 4'h4;
    localparam logic [MODE_W-1:0] MODE_DATA = 4'h5;

    // Command codes.
    localparam logic [DATA_W-1:0] CODE_READ = 16'h0011;
    localparam logic [DATA_W-1:0] CODE_WP = 16'h0012;
    localparam logic [DATA_W-1:0] CODE_WPL = 16'h0022;
    localparam logic [DATA_W-1:0] CODE_EWP = 16'h0032;
    localparam logic [DATA_W-1:0] CODE_ERASE_WRITE_LOCK_CMD = 16'h0042;
    localparam logic [DATA_W-1:0] CODE_EA = 16'h0013;
    localparam logic [DATA_W-1:0] CODE_LSET = 16'h0014;
    localparam logic [DATA_W-1:0] CODE_LCLR = 16'h0024;
    localparam logic [DATA_W-1:0] CODE_LGET = 16'h0015;
    localparam logic [DATA_W-1:0] CODE_NSET = 16'h0034;
    localparam logic [DATA_W-1:0] CODE_NCLR = 16'h0044;
    localparam logic [DATA_W-1:0] CODE_NGET = 16'h0025;
    localparam logic [DATA_W-1:0] CODE_SSET = 16'h0054;
    localparam logic [DATA_W-1:0] CODE_SGET = 16'h0035;
    localparam logic [DATA_W-1:0] CODE_MWR = 16'h001F;
    localparam logic [DATA_W-1:0] CODE_VGET = 16'h001E;

    // Decoded command presented to the flash side.
    typedef enum logic [4:0] {
        CK_NONE, CK_READ, CK_PAGE_WRITE, CK_PAGE_WRITE_LOCK, CK_ERASE_WRITE,
        CK_ERASE_WRITE_LOCK, CK_ERASE_ALL, CK_LOCK_SET, CK_LOCK_CLEAR, CK_LOCK_GET,
        CK_NVBIT_SET, CK_NVBIT_CLEAR, CK_NVBIT_GET, CK_SECURITY_SET, CK_SECURITY_GET,
        CK_MEMORY_WRITE, CK_VERSION_GET
    } pfpp_cmd_t;

    // Device handshake states, Gray in the order listed.
    typedef enum logic [2:0] {
        DEV_IDLE = 3'b000, DEV_LATCH = 3'b001, DEV_EXEC = 3'b011, DEV_WAIT_OE = 3'b010,
        DEV_FETCH = 3'b110, DEV_DRIVE = 3'b111, DEV_WAIT_HI = 3'b101
    } pfpp_dev_st_t;

    // Programmer handshake states, Gray in the order listed; PRG_REL back to PRG_IDLE flips two bits.
    typedef enum logic [2:0] {
        PRG_POR = 3'b000, PRG_IDLE = 3'b001, PRG_SETUP = 3'b011, PRG_STROBE = 3'b010,
        PRG_TRI = 3'b110, PRG_OE = 3'b111, PRG_OE_HI = 3'b101, PRG_REL = 3'b100
    } pfpp_prg_st_t;

    // Timing.
    localparam longint REF_CLK_HZ = 200_000_000;
    localparam longint EXT_MIN_HZ = 32_000;
    localparam int EXT_DETECT_CYC_DEF = int'(REF_CLK_HZ / EXT_MIN_HZ);
    localparam longint POR_WAIT_US = 10;
    localparam int POR_WAIT_CYC_DEF = int'((POR_WAIT_US * REF_CLK_HZ + 999_999) / 1_000_000);
endpackage

// ### core/pfpp_if.sv
// Purpose: Pin bundle between the gang programmer and the programming port.
// Assumes: Pins not driven by anyone read high through pull-ups.
// Notes: The shared data bus is resolved here from the two enables.

`timescale 1ns/1ps

// ============================================================
// Interface
interface pfpp_if;
    // Programmer-driven pins.
    logic cmd_strobe_n;
    logic out_enable_n;
    logic [pfpp_pkg::MODE_W-1:0] transfer_type_field;
    logic test_select;
    logic prog_enable_a;
    logic prog_enable_b;
    logic prog_enable_c;
    logic prog_enable_d;
    logic [pfpp_pkg::DATA_W-1:0] prg_data_out;
    logic prg_data_oe;
    // External main clock, driven by the bench, sampled by the device.
    logic main_clock_in;
    // Device-driven pins.
    logic [pfpp_pkg::DATA_W-1:0] dev_data_out;
    logic dev_data_oe;
    logic dev_ready;
    logic dev_ready_oe;
    logic dev_dir;
    logic dev_dir_oe;
    // Resolved pin levels.
    logic [pfpp_pkg::DATA_W-1:0] prog_data_bus;
    logic port_ready_out;
    logic bus_direction_flag;

    // Resolve each pin, a pull-up winning when nobody drives.
    assign prog_data_bus = dev_data_oe ? dev_data_out :
                           prg_data_oe ? prg_data_out : pfpp_pkg::BUS_PULLUP;
    assign port_ready_out = dev_ready_oe ? dev_ready : 1'b1;
    assign bus_direction_flag = dev_dir_oe ? dev_dir : 1'b1;

    modport dev (
        input cmd_strobe_n, out_enable_n, transfer_type_field, test_select,
        input prog_enable_a, prog_enable_b, prog_enable_c, prog_enable_d,
        input prog_data_bus, main_clock_in,
        output dev_data_out, dev_data_oe, dev_ready, dev_ready_oe, dev_dir, dev_dir_oe
    );
    modport prg (
        output cmd_strobe_n, out_enable_n, transfer_type_field, test_select,
        output prog_enable_a, prog_enable_b, prog_enable_c, prog_enable_d,
        output prg_data_out, prg_data_oe,
        input prog_data_bus, port_ready_out, bus_direction_flag
    );
endinterface // pfpp_if

// ### core/pfpp_device.sv
// Purpose: Device end of the parallel flash programming port.
// Assumes: Flash side answers each request with a one-cycle flash_ack.
// Notes: Strobe, output enable and main clock pins are resynchronised.
// Operation
// - Decode transfer type into register loads
// - Command transfer stores 16-bit command
// - Decode read, page write, write-lock codes
// - Decode erase-write, erase-all, security, memory, version
// - Decode nonvolatile and lock bit set/clear/get
// - Programmer straps test and enable pins
// - Run on RC clock unless external
// - Choose external clock before first busy
// - Programmer waits power-on interval first
// - Programmer starts only while ready high
// - Handshake ends: strobe high, ready high
// - Programmer sets type and data first
// - Capture type and data on strobe low
// - Programmer holds values until ready low
// - Execute, then raise ready after strobe high
// - Ready low busy, high when accepting
// - Direction flag high while device drives bus
// - All port pins released at reset
// - Read: drive bus under output enable
// - Advance address after each data transfer

`timescale 1ns/1ps

// ============================================================
// Device end
module pfpp_device #(
    parameter int EXT_DETECT_CYC = pfpp_pkg::EXT_DETECT_CYC_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Programming pins
    pfpp_if.dev port,
    // Flash side request
    output logic flash_req,
    output logic flash_we,
    output pfpp_pkg::pfpp_cmd_t flash_cmd,
    output logic [pfpp_pkg::ADDR_W-1:0] flash_addr,
    output logic [pfpp_pkg::DATA_W-1:0] flash_wdata,
    input wire logic flash_ack,
    input wire logic [pfpp_pkg::DATA_W-1:0] flash_rdata,
    // Status
    output logic cmd_new,
    output logic [pfpp_pkg::DATA_W-1:0] cmd_code,
    output logic clk_sel_ext,
    output logic prog_mode_ok
);
    import pfpp_pkg::*;

    localparam int CNT_W = $clog2(EXT_DETECT_CYC + 1);
    localparam int SYN_N = 3;
    localparam int SYN_STROBE = 0;
    localparam int SYN_OE = 1;
    localparam int SYN_XIN = 2;
    // Idle level of the synchronised pins: strobe and enable pulled high, clock low.
    localparam logic [SYN_N-1:0] SYN_RST = 3'b011;

    pfpp_dev_st_t state_ff, nxt_state;
    logic [SYN_N-1:0] meta_ff, sync_ff;
    logic xin_prev_ff;
    logic [MODE_W-1:0] mode_ff;
    logic [DATA_W-1:0] data_ff, cmd_ff, rdata_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic cmd_new_ff;
    logic pins_on_ff;
    logic [CNT_W-1:0] win_cnt_ff;
    logic edge_in_win_ff, ext_ok_ff, ext_sel_ff, first_done_ff;

    // ============================================================
    // Pin synchronisers
    // The first stage feeds only the second, so a metastable sample never fans out.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_ff <= SYN_RST;
            sync_ff <= SYN_RST;
        end else begin
            meta_ff <= {port.main_clock_in, port.out_enable_n, port.cmd_strobe_n};
            sync_ff <= meta_ff;
        end
    end

    wire strobe_low = ~sync_ff[SYN_STROBE];
    wire oe_low = ~sync_ff[SYN_OE];
    wire xin_rise = sync_ff[SYN_XIN] & ~xin_prev_ff;

    // ============================================================
    // Decoding
    // Strap check: test select and first two enables high, last two low.
    assign prog_mode_ok = port.test_select & port.prog_enable_a & port.prog_enable_b &
                          ~port.prog_enable_c & ~port.prog_enable_d;
    wire sel_cmd = (mode_ff == MODE_CMD);
    wire sel_addr = (mode_ff >= MODE_ADDR_LO) && (mode_ff <= MODE_ADDR_HI);
    wire sel_data = (mode_ff == MODE_DATA);
    wire [1:0] addr_idx = 2'(mode_ff - MODE_ADDR_LO); // Byte 0 is least significant.
    wire cmd_is_read = (flash_cmd == CK_READ) || (flash_cmd == CK_LOCK_GET) ||
                       (flash_cmd == CK_NVBIT_GET) || (flash_cmd == CK_SECURITY_GET) ||
                       (flash_cmd == CK_VERSION_GET);

    // Command code to operation.
    always_comb begin
        case (cmd_ff)
            CODE_READ: flash_cmd = CK_READ;
            CODE_WP: flash_cmd = CK_PAGE_WRITE;
            CODE_WPL: flash_cmd = CK_PAGE_WRITE_LOCK;
            CODE_EWP: flash_cmd = CK_ERASE_WRITE;
            CODE_ERASE_WRITE_LOCK_CMD: flash_cmd = CK_ERASE_WRITE_LOCK;
            CODE_EA: flash_cmd = CK_ERASE_ALL;
            CODE_SSET: flash_cmd = CK_SECURITY_SET;
            CODE_SGET: flash_cmd = CK_SECURITY_GET;
            CODE_MWR: flash_cmd = CK_MEMORY_WRITE;
            CODE_VGET: flash_cmd = CK_VERSION_GET;
            CODE_NSET: flash_cmd = CK_NVBIT_SET;
            CODE_NCLR: flash_cmd = CK_NVBIT_CLEAR;
            CODE_NGET: flash_cmd = CK_NVBIT_GET;
            CODE_LSET: flash_cmd = CK_LOCK_SET;
            CODE_LCLR: flash_cmd = CK_LOCK_CLEAR;
            CODE_LGET: flash_cmd = CK_LOCK_GET;
            default: flash_cmd = CK_NONE;
        endcase
    end

    // ============================================================
    // Handshake state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            DEV_IDLE: begin
                if (strobe_low && prog_mode_ok) begin
                    nxt_state = DEV_LATCH;
                end
            end
            DEV_LATCH: begin
                if (sel_data && cmd_is_read) begin
                    nxt_state = DEV_WAIT_OE;
                end else if (sel_data) begin
                    nxt_state = DEV_EXEC;
                end else begin
                    nxt_state = DEV_WAIT_HI; // Register loads and idle type finish here.
                end
            end
            DEV_EXEC: begin
                if (flash_ack) begin
                    nxt_state = DEV_WAIT_HI;
                end
            end
            DEV_WAIT_OE: begin
                if (oe_low) begin
                    nxt_state = DEV_FETCH;
                end
            end
            DEV_FETCH: begin
                if (flash_ack) begin
                    nxt_state = DEV_DRIVE;
                end
            end
            DEV_DRIVE: begin
                if (!oe_low) begin
                    nxt_state = DEV_WAIT_HI; // Bus goes back to input.
                end
            end
            DEV_WAIT_HI: begin
                if (!strobe_low) begin
                    nxt_state = DEV_IDLE;
                end
            end
            default: nxt_state = DEV_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= DEV_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ============================================================
    // Captured transfer and internal registers
    // Type and data are sampled once; the programmer holds them until ready drops.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_ff <= MODE_CMD;
            data_ff <= '0;
            cmd_ff <= '0;
            cmd_new_ff <= 1'b0;
        end else begin
            cmd_new_ff <= 1'b0;
            if (state_ff == DEV_IDLE && nxt_state == DEV_LATCH) begin
                mode_ff <= port.transfer_type_field;
                data_ff <= port.prog_data_bus;
            end
            if (state_ff == DEV_LATCH && sel_cmd) begin
                cmd_ff <= data_ff;
                cmd_new_ff <= 1'b1;
            end
        end
    end

    // Address bytes load by type; each completed data transfer steps by one.
    wire data_done = (state_ff == DEV_EXEC || state_ff == DEV_FETCH) && flash_ack;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_ff <= '0;
            rdata_ff <= '0;
        end else begin
            if (state_ff == DEV_LATCH && sel_addr) begin
                addr_ff[addr_idx*BYTE_W +: BYTE_W] <= data_ff[BYTE_W-1:0];
            end else if (data_done) begin
                addr_ff <= addr_ff + 1'b1;
            end
            if (state_ff == DEV_FETCH && flash_ack) begin
                rdata_ff <= flash_rdata;
            end
        end
    end

    // ============================================================
    // Clock source detection
    // An edge inside every window of one slow-clock period means a clock above the floor.
    // The choice freezes at the first busy, so the source never changes mid-session.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            xin_prev_ff <= 1'b0;
            win_cnt_ff <= '0;
            edge_in_win_ff <= 1'b0;
            ext_ok_ff <= 1'b0;
            ext_sel_ff <= 1'b0; // RC after reset.
            first_done_ff <= 1'b0;
        end else begin
            xin_prev_ff <= sync_ff[SYN_XIN];
            if (win_cnt_ff == CNT_W'(EXT_DETECT_CYC - 1)) begin
                win_cnt_ff <= '0;
                ext_ok_ff <= edge_in_win_ff | xin_rise; // Grounded input never passes.
                edge_in_win_ff <= 1'b0;
            end else begin
                win_cnt_ff <= win_cnt_ff + 1'b1;
                edge_in_win_ff <= edge_in_win_ff | xin_rise;
            end
            if (!first_done_ff && state_ff == DEV_IDLE && nxt_state == DEV_LATCH) begin
                // An edge in the open window counts too: the power-on wait is shorter
                // than one window, at the cost that a very slow clock may pass early.
                ext_sel_ff <= ext_ok_ff | edge_in_win_ff | xin_rise;
                first_done_ff <= 1'b1;
            end
        end
    end

    // Pins come up released and are taken over one cycle after reset.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pins_on_ff <= 1'b0;
        end else begin
            pins_on_ff <= 1'b1;
        end
    end

    // ============================================================
    // Outputs
    assign port.dev_ready = (state_ff == DEV_IDLE);
    assign port.dev_ready_oe = pins_on_ff;
    assign port.dev_dir = (state_ff == DEV_DRIVE);
    assign port.dev_dir_oe = pins_on_ff;
    assign port.dev_data_out = rdata_ff;
    assign port.dev_data_oe = (state_ff == DEV_DRIVE);
    assign flash_req = (state_ff == DEV_EXEC) || (state_ff == DEV_FETCH);
    assign flash_we = (state_ff == DEV_EXEC);
    assign flash_addr = addr_ff;
    assign flash_wdata = data_ff;
    assign cmd_new = cmd_new_ff;
    assign cmd_code = cmd_ff;
    assign clk_sel_ext = ext_sel_ff;
endmodule // pfpp_device

// ### core/pfpp_programmer.sv
// Purpose: Gang programmer end of the parallel flash programming port.
// Assumes: One transfer per user request; device pins sampled on ref_clk.
// Notes: Holds off all requests until the power-on interval has elapsed.

`timescale 1ns/1ps

// ============================================================
// Programmer end
module pfpp_programmer #(
    parameter int POR_WAIT_CYC = pfpp_pkg::POR_WAIT_CYC_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Programming pins
    pfpp_if.prg port,
    // User request
    input wire logic req,
    input wire logic req_read,
    input wire logic [pfpp_pkg::MODE_W-1:0] req_mode,
    input wire logic [pfpp_pkg::DATA_W-1:0] req_wdata,
    // User answer
    output logic busy,
    output logic done,
    output logic [pfpp_pkg::DATA_W-1:0] rdata
);
    import pfpp_pkg::*;

    localparam int POR_W = $clog2(POR_WAIT_CYC + 1);

    pfpp_prg_st_t state_ff, nxt_state;
    logic [POR_W-1:0] por_cnt_ff;
    logic read_ff, done_ff;
    logic [MODE_W-1:0] mode_ff;
    logic [DATA_W-1:0] wdata_ff, rdata_ff;

    wire dev_ready = port.port_ready_out;
    wire dev_drives = port.bus_direction_flag;
    wire por_over = (por_cnt_ff == POR_W'(POR_WAIT_CYC));

    // ============================================================
    // Handshake state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PRG_POR: if (por_over) begin
                nxt_state = PRG_IDLE;
            end
            PRG_IDLE: if (req) begin
                nxt_state = PRG_SETUP;
            end
            PRG_SETUP: if (dev_ready) begin
                nxt_state = PRG_STROBE;
            end
            PRG_STROBE: if (!dev_ready) begin
                nxt_state = read_ff ? PRG_TRI : PRG_REL;
            end
            PRG_TRI: nxt_state = PRG_OE; // Bus released a cycle before enable.
            PRG_OE: if (dev_drives) begin
                nxt_state = PRG_OE_HI;
            end
            PRG_OE_HI: if (!dev_drives) begin
                nxt_state = PRG_REL;
            end
            PRG_REL: if (dev_ready) begin
                nxt_state = PRG_IDLE;
            end
            default: nxt_state = PRG_POR;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= PRG_POR;
            por_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (!por_over) begin
                por_cnt_ff <= por_cnt_ff + 1'b1;
            end
        end
    end

    // ============================================================
    // Request capture and read data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            read_ff <= 1'b0;
            mode_ff <= MODE_CMD;
            wdata_ff <= '0;
            rdata_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == PRG_REL) && dev_ready;
            if (state_ff == PRG_IDLE && req) begin
                read_ff <= req_read;
                mode_ff <= req_mode;
                wdata_ff <= req_wdata;
            end
            if (state_ff == PRG_OE && dev_drives) begin
                rdata_ff <= port.prog_data_bus;
            end
        end
    end

    // ============================================================
    // Pin drive
    // Mode and data stand from setup until the device has gone busy.
    wire hold_vals = (state_ff == PRG_SETUP) || (state_ff == PRG_STROBE);
    assign port.test_select = 1'b1;
    assign port.prog_enable_a = 1'b1;
    assign port.prog_enable_b = 1'b1;
    assign port.prog_enable_c = 1'b0;
    assign port.prog_enable_d = 1'b0;
    assign port.transfer_type_field = mode_ff;
    assign port.prg_data_out = wdata_ff;
    assign port.prg_data_oe = hold_vals;
    assign port.cmd_strobe_n = (state_ff != PRG_STROBE) && (state_ff != PRG_TRI) &&
                               (state_ff != PRG_OE) && (state_ff != PRG_OE_HI);
    assign port.out_enable_n = (state_ff != PRG_OE);
    assign busy = (state_ff != PRG_IDLE);
    assign done = done_ff;
    assign rdata = rdata_ff;
endmodule // pfpp_programmer

// ### sim/pfpp_properties.sv
// Purpose: Pin-level handshake checks between the two port ends.
// Assumes: One clock; pins as resolved by the interface.
// Notes: Ranges leave slack for the two-stage synchroniser.
`timescale 1ns/1ps
// ============================================================
// Checker
module pfpp_properties (
    // Clock and reset
    input logic ref_clk,
    input logic rst_n,
    // Port pins and enables
    input logic cmd_strobe_n,
    input logic out_enable_n,
    input logic prg_data_oe,
    input logic dev_data_oe,
    input logic dev_dir_oe,
    input logic port_ready_out,
    input logic bus_direction_flag
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Busy must follow a taken strobe, and hold while the strobe stays low.
    chk_ready_drop: assert property ($fell(cmd_strobe_n) |-> ##[2:6] !port_ready_out)
        else $error("ready did not drop after strobe");
    chk_ready_hold: assert property (!port_ready_out && !cmd_strobe_n |=> !port_ready_out)
        else $error("ready rose while strobe low");
    chk_ready_rise: assert property ($rose(port_ready_out) |-> cmd_strobe_n && $past(cmd_strobe_n))
        else $error("ready rose before strobe returned high");
    chk_idle_ready: assert property (port_ready_out && cmd_strobe_n |=> port_ready_out)
        else $error("ready dropped with no strobe");
    // The flag tracks who owns the data bus; both owning it would short the pins.
    chk_dir_drive: assert property (dev_dir_oe |-> bus_direction_flag == dev_data_oe)
        else $error("direction flag disagrees with bus drive");
    chk_no_clash: assert property (!(dev_data_oe && prg_data_oe))
        else $error("both ends drive the data bus");
    chk_drive_start: assert property ($rose(dev_data_oe) |-> !out_enable_n && !cmd_strobe_n)
        else $error("device drove bus without output enable");
    chk_drive_end: assert property ($rose(out_enable_n) |-> ##[1:6] !dev_data_oe)
        else $error("device kept bus after output enable rose");
    // Reset must release the data bus, ready and direction pins, so this one is never disabled.
    chk_reset_pins: assert property (disable iff (1'b0)
        !rst_n |=> !dev_data_oe && !prg_data_oe && port_ready_out && bus_direction_flag)
        else $error("pins not released in reset");
    cover property ($rose(dev_data_oe));
    cover property ($fell(port_ready_out));
    cover property ($rose(rst_n));
endmodule // pfpp_properties

// ### sim/pfpp_tb_top.sv
// Purpose: Self-checking bench joining both ends of the programming port.
// Assumes: The flash side answers one cycle after each request.
// Notes: Short detect and power-on counts keep the run brief.
`timescale 1ns/1ps
// ============================================================
// Bench
module pfpp_tb_top;
    import pfpp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic req_read = 1'b0;
    logic [MODE_W-1:0] req_mode = 4'h0;
    logic [DATA_W-1:0] req_wdata = 16'h0000;
    logic busy, done, flash_req, flash_we, cmd_new, clk_sel_ext, prog_mode_ok, l_we;
    logic flash_ack = 1'b0;
    logic ext_run = 1'b1;
    logic [DATA_W-1:0] rdata, flash_wdata, flash_rdata, cmd_code, l_wd;
    logic [ADDR_W-1:0] flash_addr, l_addr;
    pfpp_cmd_t flash_cmd, l_cmd;
    int errors = 0;
    int tests_run = 0;
    int n_fl = 0;
    int n_new = 0;
    pfpp_if i_pfpp_if ();
    pfpp_device #(.EXT_DETECT_CYC(16)) i_pfpp_device (.ref_clk(ref_clk), .rst_n(rst_n),
        .port(i_pfpp_if.dev), .flash_req(flash_req), .flash_we(flash_we),
        .flash_cmd(flash_cmd), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_ack(flash_ack), .flash_rdata(flash_rdata), .cmd_new(cmd_new),
        .cmd_code(cmd_code), .clk_sel_ext(clk_sel_ext), .prog_mode_ok(prog_mode_ok));
    pfpp_programmer #(.POR_WAIT_CYC(8)) i_pfpp_programmer (.ref_clk(ref_clk), .rst_n(rst_n),
        .port(i_pfpp_if.prg), .req(req), .req_read(req_read), .req_mode(req_mode),
        .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata));
    pfpp_properties i_pfpp_properties (.ref_clk(ref_clk), .rst_n(rst_n),
        .cmd_strobe_n(i_pfpp_if.cmd_strobe_n), .out_enable_n(i_pfpp_if.out_enable_n),
        .prg_data_oe(i_pfpp_if.prg_data_oe), .dev_data_oe(i_pfpp_if.dev_data_oe),
        .dev_dir_oe(i_pfpp_if.dev_dir_oe), .port_ready_out(i_pfpp_if.port_ready_out),
        .bus_direction_flag(i_pfpp_if.bus_direction_flag));
    // Clocks; the main clock input falls to ground once disabled.
    always #2.5 ref_clk = ~ref_clk;
    initial i_pfpp_if.main_clock_in = 1'b0;
    always #10 i_pfpp_if.main_clock_in = ext_run & ~i_pfpp_if.main_clock_in;
    // Flash side: data depends on address so a stale address shows up on reads.
    assign flash_rdata = flash_addr[15:0] ^ 16'h5A5A;
    always @(posedge ref_clk) begin
        flash_ack <= rst_n && flash_req && !flash_ack;
        if (flash_req && flash_ack) begin
            n_fl <= n_fl + 1;
            l_we <= flash_we;
            l_cmd <= flash_cmd;
            l_addr <= flash_addr;
            l_wd <= flash_wdata;
        end
        if (cmd_new === 1'b1) n_new <= n_new + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One transfer through the programmer; a missing done counts as a mismatch.
    task automatic xfer(input logic rd, input logic [3:0] m, input logic [15:0] d);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        req <= 1'b1;
        req_read <= rd;
        req_mode <= m;
        req_wdata <= d;
        @(posedge ref_clk);
        req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400) chk(32'h0, 32'h1);
    endtask
    // Every command code, each followed by one data transfer, read kinds as reads.
    task automatic t_cmds();
        logic [15:0] code [16] = '{16'h0011, 16'h0012, 16'h0022, 16'h0032, 16'h0042,
            16'h0013, 16'h0014, 16'h0024, 16'h0015, 16'h0034, 16'h0044, 16'h0025,
            16'h0054, 16'h0035, 16'h001F, 16'h001E};
        logic [15:0] rk = 16'hA901;
        int b;
        for (int i = 0; i < 16; i++) begin
            b = n_new;
            xfer(1'b0, MODE_CMD, code[i]);
            chk(32'(cmd_code), 32'(code[i]));
            chk(32'(n_new - b), 32'h1);
            xfer(rk[i], MODE_DATA, 16'(i));
            chk(32'(l_cmd), 32'(i + 1));
            chk(32'(l_we), 32'(!rk[i]));
        end
        chk(32'(clk_sel_ext), 32'h1);
        chk(32'(prog_mode_ok), 32'h1);
    endtask
    // Address bytes, chained writes, idle types and chained reads.
    task automatic t_addr();
        int f;
        xfer(1'b0, MODE_CMD, CODE_WP);
        for (int k = 1; k <= 4; k++) xfer(1'b0, 4'(k), 16'hAB00 | 16'(k * 17));
        for (int j = 0; j < 2; j++) begin
            xfer(1'b0, MODE_DATA, 16'hC3C0 + 16'(j));
            chk(l_addr, 32'h4433_2211 + 32'(j));
            chk(32'(l_wd), 32'h0000_C3C0 + 32'(j));
        end
        f = n_fl;
        for (int m = 6; m < 16; m++) xfer(1'b0, 4'(m), 16'hFFFF);
        chk(32'(n_fl - f), 32'h0);
        xfer(1'b0, MODE_CMD, CODE_READ);
        for (int j = 2; j < 4; j++) begin
            xfer(1'b1, MODE_DATA, 16'h0000);
            chk(l_addr, 32'h4433_2211 + 32'(j));
            chk(32'(rdata), 32'((16'h2211 + 16'(j)) ^ 16'h5A5A));
        end
    endtask
    // Second reset with the main clock input grounded.
    task automatic t_noext();
        ext_run = 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        xfer(1'b0, MODE_CMD, CODE_EA);
        chk(32'(clk_sel_ext), 32'h0);
        chk(32'(cmd_code), 32'(CODE_EA));
    endtask
    task automatic results();
        $display("Checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_cmds();
        t_addr();
        t_noext();
        results();
    end
    // Watchdog far beyond the fewer than a thousand cycles the tests need.
    initial begin
        #200000;
        errors++;
        results();
    end
endmodule // pfpp_tb_top
